// ==== hw/otsc_pkg.sv ====
package otsc_pkg;
  // ----------------------------------------
  // configuration codes
  // ----------------------------------------
  localparam logic [3:0]  FWD_ASSIGN_ON   = 4'h1;
  localparam logic [3:0]  REV_ASSIGN_ON   = 4'h2;
  localparam logic [3:0]  ASSIGN_OFF      = 4'h8;
  localparam logic [3:0]  STOP_LO_DB      = 4'h0;
  localparam logic [3:0]  STOP_LO_DB_CST  = 4'h1;
  localparam logic [3:0]  STOP_LO_CST     = 4'h2;
  localparam logic [3:0]  STOP_HI_NONE    = 4'h0;
  localparam logic [3:0]  STOP_HI_TRQ_ZC  = 4'h1;
  localparam logic [3:0]  STOP_HI_TRQ_CST = 4'h2;
  localparam logic [3:0]  STOP_HI_TIM_ZC  = 4'h3;
  localparam logic [3:0]  STOP_HI_TIM_CST = 4'h4;
  // ----------------------------------------
  // widths, defaults and timing
  // ----------------------------------------
  localparam int          SPD_W           = 16;
  localparam int          TRQ_W           = 10;
  localparam int          DEC_W           = 14;
  localparam logic [9:0]  ESTOP_TRQ_DEF   = 10'h320;
  localparam logic [13:0] DECEL_MS_DEF    = 14'h0000;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          MS_NS           = 1_000_000;
  localparam int          CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int          MS_CYCLES       = MS_NS / CLK_NS;
  localparam logic [16:0] MS_CYC          = 17'(MS_CYCLES);
  localparam logic [15:0] MAX_SPEED       = 16'h7FFF;
  typedef enum logic [1:0] {OTSC_DRIVE, OTSC_STOPPING, OTSC_HELD} otsc_phase_t;
  typedef enum logic [1:0] {OTSC_OUT_RUN, OTSC_OUT_DB, OTSC_OUT_COAST, OTSC_OUT_CLAMP} otsc_mode_t;
endpackage

// ==== hw/otsc_ramp_if.sv ====
`timescale 1ns/1ps
interface otsc_ramp_if;
  logic        start;
  logic [15:0] speed_in;
  logic [13:0] decel_ms;
  logic [15:0] speed_out;
  logic        done;
  modport ctrl (output start, output speed_in, output decel_ms, input speed_out, input done);
  modport ramp (input start, input speed_in, input decel_ms, output speed_out, output done);
endinterface

// ==== hw/otsc_ramp.sv ====
`timescale 1ns/1ps
module otsc_ramp
  import otsc_pkg::*;
(
  input  wire logic  core_clk, // system clock
  input  wire logic  rst,      // sync reset
  otsc_ramp_if.ramp  rp        // ramp request and result
);
  typedef struct packed {
    logic [15:0] spd;
    logic [16:0] cyc;
    logic [13:0] ms_left;
    logic [15:0] step;
    logic        busy;
    logic        done;
  } otsc_ramp_st_t;
  otsc_ramp_st_t st_r, st_nxt;
  logic [15:0] step_c;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    // per-ms step = max speed / decel time; rounds up so ramp never overruns
    step_c = (rp.decel_ms == 14'h0000) ? MAX_SPEED :
             16'((32'(MAX_SPEED) + 32'(rp.decel_ms) - 32'h1) / 32'(rp.decel_ms));
    if (rp.start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cyc = 17'h0;
      st_nxt.ms_left = rp.decel_ms;
      st_nxt.step = step_c;
      if (rp.decel_ms == 14'h0000) begin
        st_nxt.spd = 16'h0000;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.spd = rp.speed_in;
      end
    end else if (st_r.busy) begin
      if (st_r.cyc == MS_CYC - 17'h1) begin
        st_nxt.cyc = 17'h0;
        if (st_r.spd <= st_r.step) begin
          st_nxt.spd = 16'h0000;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.spd = st_r.spd - st_r.step;
        end
      end else begin
        st_nxt.cyc = st_r.cyc + 17'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign rp.speed_out = st_r.spd;
  assign rp.done = st_r.done;

  chk_zero_time_stop: assert property (@(posedge core_clk) disable iff (rst)
    rp.start && rp.decel_ms == 14'h0000 |=> st_r.spd == 16'h0000 && rp.done)
    else $error("zero decel time did not stop at once");
endmodule

// ==== hw/otsc_top.sv ====
`timescale 1ns/1ps
module otsc_top
  import otsc_pkg::*;
(
  input  wire logic                  core_clk,              // 100 MHz clock
  input  wire logic                  rst,                   // sync reset, active high
  input  wire logic                  forward_limit_input,   // limit pin, high = drive permitted
  input  wire logic                  reverse_limit_input,   // limit pin, high = drive permitted
  input  wire logic [3:0]            forward_limit_assign,  // sampled at restart
  input  wire logic [3:0]            reverse_limit_assign,  // sampled at restart
  input  wire logic [7:0]            stop_method_select,    // [7:4] upper, [3:0] lower digit, at restart
  input  wire logic [9:0]            emergency_stop_torque, // percent of rated torque
  input  wire logic [13:0]           stop_decel_time,       // ms, max speed to zero
  input  wire logic                  torque_mode,           // host runs torque control
  input  wire logic                  ref_valid,             // motion reference present
  input  wire logic                  ref_dir_rev,           // reference direction, 1 = reverse
  input  wire logic [15:0]           ref_speed,             // reference speed magnitude
  input  wire logic                  motor_stopped,         // speed feedback is zero
  input  wire logic                  servo_on,              // servo enabled
  output logic                       fwd_overtravel,        // forward prohibit active
  output logic                       rev_overtravel,        // reverse prohibit active
  output logic                       drive_enable,          // power stage on (low = base block)
  output logic                       dyn_brake,             // dynamic brake engaged
  output logic                       zero_clamp,            // hold position at zero
  output logic [15:0]                speed_cmd,             // speed command to loop
  output logic [9:0]                 torque_limit,          // active torque limit, percent
  output logic                       brake_release_output,  // holding brake released
  output otsc_mode_t                 stop_mode              // present output mode
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] fwd_sync_r, rev_sync_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // reset to the closed-switch level, else a false overtravel follows every reset
      fwd_sync_r <= 2'h3;
      rev_sync_r <= 2'h3;
    end else begin
      fwd_sync_r <= {fwd_sync_r[0], forward_limit_input};
      rev_sync_r <= {rev_sync_r[0], reverse_limit_input};
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic        cfg_ok;
    logic        fwd_en;
    logic [3:0]  hi;
    logic [3:0]  lo;
    otsc_phase_t phase;
    logic        stop_dir_rev;
    logic        ramp_used;
    logic        fwd_ot;
    logic        rev_ot;
    logic        rev_en;
    logic        drv;
    logic        db;
    logic        zc;
    logic [15:0] spd;
    logic [9:0]  trq;
    logic        brk;
    otsc_mode_t  mode;
  } otsc_state_t;
  otsc_state_t st_r, st_nxt;

  otsc_ramp_if rif();
  logic fwd_pin, rev_pin, fwd_pro, rev_pro, hit, decel_ok, zc_after;

  assign fwd_pin = fwd_sync_r[1];
  assign rev_pin = rev_sync_r[1];

  always_comb begin
    st_nxt = st_r;
    rif.start = 1'b0;
    rif.speed_in = st_r.spd;
    rif.decel_ms = stop_decel_time;
    // settings are taken once after restart, so later changes wait for the next reset
    if (!st_r.cfg_ok) begin
      st_nxt.cfg_ok = 1'b1;
      st_nxt.fwd_en = (forward_limit_assign != ASSIGN_OFF);
      st_nxt.rev_en = (reverse_limit_assign != ASSIGN_OFF);
      st_nxt.hi = stop_method_select[7:4];
      st_nxt.lo = stop_method_select[3:0];
    end
    fwd_pro = st_r.fwd_en && !fwd_pin;
    rev_pro = st_r.rev_en && !rev_pin;
    st_nxt.fwd_ot = st_r.cfg_ok && fwd_pro;
    st_nxt.rev_ot = st_r.cfg_ok && rev_pro;
    hit = st_r.cfg_ok && ref_valid && (ref_dir_rev ? rev_pro : fwd_pro);
    decel_ok = !torque_mode && st_r.hi != STOP_HI_NONE;
    zc_after = st_r.hi == STOP_HI_TRQ_ZC || st_r.hi == STOP_HI_TIM_ZC;
    st_nxt.brk = servo_on;
    unique case (st_r.phase)
      OTSC_DRIVE: begin
        st_nxt.drv = servo_on;
        st_nxt.db = 1'b0;
        st_nxt.zc = 1'b0;
        st_nxt.trq = 10'h3FF;
        st_nxt.mode = OTSC_OUT_RUN;
        st_nxt.spd = ref_valid ? ref_speed : 16'h0000;
        if (hit && servo_on) begin
          st_nxt.phase = OTSC_STOPPING;
          st_nxt.stop_dir_rev = ref_dir_rev;
          st_nxt.ramp_used = decel_ok && (st_r.hi == STOP_HI_TIM_ZC || st_r.hi == STOP_HI_TIM_CST);
          if (decel_ok && (st_r.hi == STOP_HI_TRQ_ZC || st_r.hi == STOP_HI_TRQ_CST)) begin
            st_nxt.trq = emergency_stop_torque;
            st_nxt.spd = 16'h0000;
          end else if (decel_ok) begin
            rif.start = 1'b1;
          end else begin
            st_nxt.spd = 16'h0000;
            st_nxt.drv = 1'b0;
            st_nxt.db = (st_r.lo != STOP_LO_CST);
            st_nxt.mode = st_nxt.db ? OTSC_OUT_DB : OTSC_OUT_COAST;
          end
        end
      end
      OTSC_STOPPING: begin
        if (st_r.ramp_used) begin
          st_nxt.spd = rif.speed_out;
          st_nxt.trq = 10'h3FF;
        end else if (st_r.drv) begin
          st_nxt.trq = emergency_stop_torque;
        end
        if ((st_r.ramp_used ? rif.done : motor_stopped)) begin
          st_nxt.phase = OTSC_HELD;
          st_nxt.spd = 16'h0000;
          if (decel_ok && zc_after) begin
            st_nxt.zc = 1'b1;
            st_nxt.drv = 1'b1;
            st_nxt.mode = OTSC_OUT_CLAMP;
          end else begin
            st_nxt.drv = 1'b0;
            // brake-then-coast releases the dynamic brake once stopped
            st_nxt.db = decel_ok ? 1'b0 : (st_r.lo == STOP_LO_DB) && !torque_mode;
            st_nxt.mode = st_nxt.db ? OTSC_OUT_DB : OTSC_OUT_COAST;
          end
        end
      end
      OTSC_HELD: begin
        // a reference away from the limit, or the limit clearing, returns to drive
        if (!(st_r.stop_dir_rev ? rev_pro : fwd_pro) ||
            (ref_valid && ref_dir_rev != st_r.stop_dir_rev)) begin
          st_nxt.phase = OTSC_DRIVE;
        end
      end
    endcase
    if (!servo_on) begin
      st_nxt.drv = 1'b0;
      st_nxt.zc = 1'b0;
      st_nxt.spd = 16'h0000;
      st_nxt.phase = OTSC_DRIVE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.phase <= OTSC_DRIVE;
      st_r.mode <= OTSC_OUT_RUN;
      st_r.trq <= ESTOP_TRQ_DEF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // deceleration ramp
  // ----------------------------------------
  otsc_ramp u_ramp (
    .core_clk (core_clk),
    .rst      (rst),
    .rp       (rif.ramp)
  );

  assign fwd_overtravel = st_r.fwd_ot;
  assign rev_overtravel = st_r.rev_ot;
  assign drive_enable = st_r.drv;
  assign dyn_brake = st_r.db;
  assign zero_clamp = st_r.zc;
  assign speed_cmd = st_r.spd;
  assign torque_limit = st_r.trq;
  assign brake_release_output = st_r.brk;
  assign stop_mode = st_r.mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_fwd_prohibit: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg_ok && st_r.fwd_en && !fwd_pin |=> fwd_overtravel)
    else $error("forward overtravel not flagged");
  chk_rev_prohibit: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg_ok && st_r.rev_en && !rev_pin |=> rev_overtravel)
    else $error("reverse overtravel not flagged");
  chk_disabled_fwd: assert property (@(posedge core_clk) disable iff (rst)
    !st_r.fwd_en |=> !fwd_overtravel)
    else $error("disabled forward limit acted");
  chk_disabled_rev: assert property (@(posedge core_clk) disable iff (rst)
    !st_r.rev_en |=> !rev_overtravel)
    else $error("disabled reverse limit acted");
  chk_opposite_runs: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && servo_on && ref_valid && !hit |=> speed_cmd == $past(ref_speed))
    else $error("opposite reference not executed");
  chk_db_stop: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && !decel_ok && st_r.lo == STOP_LO_DB |=> dyn_brake && !drive_enable)
    else $error("dynamic brake stop missing");
  chk_estop_torque: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && decel_ok && st_r.hi == STOP_HI_TRQ_ZC
    |=> torque_limit == $past(emergency_stop_torque))
    else $error("emergency torque not applied");
  chk_torque_no_clamp: assert property (@(posedge core_clk) disable iff (rst)
    torque_mode && st_r.phase == OTSC_STOPPING && motor_stopped && !st_r.ramp_used |=> !zero_clamp)
    else $error("torque control clamped");
  chk_base_block: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_HELD && !zero_clamp |-> !drive_enable)
    else $error("drive on in base block");
  chk_brake_held: assert property (@(posedge core_clk) disable iff (rst)
    servo_on && (fwd_overtravel || rev_overtravel) |=> brake_release_output)
    else $error("brake engaged on overtravel");
  chk_fwd_clear: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg_ok && fwd_pin |=> !fwd_overtravel)
    else $error("forward overtravel with limit closed");
  chk_rev_clear: assert property (@(posedge core_clk) disable iff (rst)
    st_r.cfg_ok && rev_pin |=> !rev_overtravel)
    else $error("reverse overtravel with limit closed");
  chk_fwd_ref_stop: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && servo_on && ref_valid && !ref_dir_rev && st_r.cfg_ok && st_r.fwd_en && !fwd_pin
    |=> st_r.phase == OTSC_STOPPING)
    else $error("forward stop not started");
  chk_rev_ref_stop: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && servo_on && ref_valid && ref_dir_rev && st_r.cfg_ok && st_r.rev_en && !rev_pin
    |=> st_r.phase == OTSC_STOPPING)
    else $error("reverse stop not started");
  chk_disabled_no_stop: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && servo_on && ref_valid && !(ref_dir_rev ? st_r.rev_en : st_r.fwd_en)
    |=> st_r.phase == OTSC_DRIVE)
    else $error("disabled limit started a stop");
  chk_held_resume: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_HELD && servo_on && ref_valid && ref_dir_rev != st_r.stop_dir_rev
    |=> st_r.phase == OTSC_DRIVE)
    else $error("opposite reference did not resume drive");

  // ----------------------------------------
  // stop sequence checks
  // ----------------------------------------
  chk_coast_stop: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && !decel_ok && st_r.lo == STOP_LO_CST
    |=> !dyn_brake && !drive_enable && stop_mode == OTSC_OUT_COAST)
    else $error("coasting stop wrong");
  chk_db_release: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_STOPPING && !st_r.ramp_used && motor_stopped && st_r.lo == STOP_LO_DB_CST |=> !dyn_brake)
    else $error("dynamic brake kept after brake-then-coast stop");
  chk_estop_coast: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && decel_ok && st_r.hi == STOP_HI_TRQ_CST
    |=> torque_limit == $past(emergency_stop_torque) && speed_cmd == 16'h0000)
    else $error("emergency torque stop wrong");
  chk_estop_hold: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_STOPPING && !st_r.ramp_used && st_r.drv |=> torque_limit == $past(emergency_stop_torque))
    else $error("emergency torque not held while stopping");
  chk_ramp_start: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && decel_ok &&
    (st_r.hi == STOP_HI_TIM_ZC || st_r.hi == STOP_HI_TIM_CST) |-> rif.start)
    else $error("deceleration ramp not started");
  chk_ramp_follow: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_STOPPING && st_r.ramp_used && servo_on && !rif.done |=> speed_cmd == $past(rif.speed_out))
    else $error("speed command not following ramp");
  chk_clamp_after: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_STOPPING && servo_on && decel_ok && zc_after && (st_r.ramp_used ? rif.done : motor_stopped)
    |=> zero_clamp && drive_enable && stop_mode == OTSC_OUT_CLAMP)
    else $error("zero clamp not entered");
  chk_coast_after: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_STOPPING && !(decel_ok && zc_after) && (st_r.ramp_used ? rif.done : motor_stopped)
    |=> !drive_enable && !zero_clamp)
    else $error("base block not entered after stop");
  chk_torque_no_decel: assert property (@(posedge core_clk) disable iff (rst)
    st_r.phase == OTSC_DRIVE && hit && servo_on && torque_mode |=> !drive_enable && speed_cmd == 16'h0000)
    else $error("torque control decelerated");
  chk_torque_coast_end: assert property (@(posedge core_clk) disable iff (rst)
    torque_mode && st_r.phase == OTSC_STOPPING && !st_r.ramp_used && motor_stopped |=> !dyn_brake)
    else $error("torque control not coasting after stop");
  chk_servo_off: assert property (@(posedge core_clk) disable iff (rst)
    !servo_on |=> !drive_enable && !zero_clamp && speed_cmd == 16'h0000)
    else $error("drive left on with servo off");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  cov_torque_stop: cover property (@(posedge core_clk) torque_mode && st_r.phase == OTSC_STOPPING);
  cov_fwd_stop: cover property (@(posedge core_clk) st_r.phase == OTSC_DRIVE && hit && !ref_dir_rev);
  cov_ramp_done: cover property (@(posedge core_clk) st_r.ramp_used && rif.done);
  cov_clamp: cover property (@(posedge core_clk) zero_clamp);
  cov_resume: cover property (@(posedge core_clk) st_r.phase == OTSC_HELD ##1 st_r.phase == OTSC_DRIVE);
endmodule

// ==== tb/otsc_far_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// limit switches and a motor that coasts to rest some time after drive stops
// ----------------------------------------
module otsc_far_model
  import otsc_pkg::*;
#(
  parameter int STOP_LAG = 20
)
(
  input  wire logic        core_clk,            // system clock
  input  wire logic        fwd_hit,             // carriage sits on forward switch
  input  wire logic        rev_hit,             // carriage sits on reverse switch
  input  wire logic        drive_enable,        // power stage on
  input  wire logic [15:0] speed_cmd,           // commanded speed
  output logic             forward_limit_input, // normally closed, opens on hit
  output logic             reverse_limit_input, // normally closed, opens on hit
  output logic             motor_stopped        // speed feedback is zero
);
  int lag_cnt = 0;
  // normally closed contacts: a broken wire reads as a hit, never as free travel
  assign forward_limit_input = !fwd_hit;
  assign reverse_limit_input = !rev_hit;
  // motor needs STOP_LAG idle cycles to come to rest, so stop outputs must hold meanwhile
  always @(posedge core_clk) begin
    if (drive_enable && speed_cmd != 16'h0000) begin
      lag_cnt <= 0;
    end else if (lag_cnt < STOP_LAG) begin
      lag_cnt <= lag_cnt + 1;
    end
  end
  assign motor_stopped = (lag_cnt >= STOP_LAG);
endmodule

// ==== tb/otsc_top_bench.sv ====
`timescale 1ns/1ps
module otsc_top_bench;
  import otsc_pkg::*;
  logic core_clk = 0, rst = 1, fwd_hit = 0, rev_hit = 0, fli, rli, torque_mode = 0;
  logic ref_valid = 0, ref_dir_rev = 0, motor_stopped, servo_on = 0;
  logic [3:0] fa = 4'h1, ra = 4'h2;
  logic [7:0] sm = 8'h00;
  logic [15:0] ref_speed = 16'h1000, speed_cmd;
  logic fwd_ot, rev_ot, drive_enable, dyn_brake, zero_clamp, brk;
  logic [9:0] torque_limit;
  otsc_mode_t stop_mode;
  int err_count = 0, checks = 0;
  logic [7:0] sm_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h30, 8'h40};
  initial forever #5 core_clk = ~core_clk;
  otsc_top i_dut (.core_clk(core_clk), .rst(rst), .forward_limit_input(fli), .reverse_limit_input(rli),
    .forward_limit_assign(fa), .reverse_limit_assign(ra), .stop_method_select(sm),
    .emergency_stop_torque(10'h1F4), .stop_decel_time(14'h0000), .torque_mode(torque_mode),
    .ref_valid(ref_valid), .ref_dir_rev(ref_dir_rev), .ref_speed(ref_speed), .motor_stopped(motor_stopped),
    .servo_on(servo_on), .fwd_overtravel(fwd_ot), .rev_overtravel(rev_ot), .drive_enable(drive_enable),
    .dyn_brake(dyn_brake), .zero_clamp(zero_clamp), .speed_cmd(speed_cmd), .torque_limit(torque_limit),
    .brake_release_output(brk), .stop_mode(stop_mode));
  otsc_far_model i_far (.core_clk(core_clk), .fwd_hit(fwd_hit), .rev_hit(rev_hit), .drive_enable(drive_enable),
    .speed_cmd(speed_cmd), .forward_limit_input(fli), .reverse_limit_input(rli), .motor_stopped(motor_stopped));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for the output mode; running out counts as a mismatch
  task automatic wait_mode(input otsc_mode_t m);
    int i;
    for (i = 0; i < 300 && stop_mode !== m; i++) cyc(1);
    chk(16'(stop_mode), 16'(m));
    if (i >= 300) tally_and_finish();
  endtask
  // config is only taken at restart, so every setting change goes through reset
  task automatic restart(input logic [3:0] f, input logic [3:0] r, input logic [7:0] s);
    rst = 1; fwd_hit = 0; rev_hit = 0; fa = f; ra = r; sm = s;
    cyc(16);
    chk(16'(torque_limit), 16'h0320);
    chk(16'(stop_mode), 16'(OTSC_OUT_RUN));
    rst = 0; servo_on = 1; ref_valid = 1; ref_dir_rev = 0;
    cyc(6);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [3:0] hi, lo;
    cyc(1);
    foreach (sm_tab[k]) begin
      hi = sm_tab[k][7:4];
      lo = sm_tab[k][3:0];
      restart(4'h1, 4'h2, sm_tab[k]);
      chk(16'({fwd_ot, drive_enable}), 16'h0001);
      chk(speed_cmd, ref_speed);
      fwd_hit = 1;
      cyc(5);
      chk(16'(fwd_ot), 16'h0001);
      chk(16'(brk), 16'h0001);
      if (hi == 4'h0) chk(16'({dyn_brake, drive_enable}), {14'h0, lo != 4'h2, 1'b0});
      if (hi == 4'h1 || hi == 4'h2) chk(16'(torque_limit), 16'h01F4);
      if (hi >= 4'h3) chk(speed_cmd, 16'h0000);
      if (hi == 4'h1 || hi == 4'h3) wait_mode(OTSC_OUT_CLAMP);
      else if (sm_tab[k] == 8'h00) wait_mode(OTSC_OUT_DB);
      else wait_mode(OTSC_OUT_COAST);
      if (hi == 4'h1 || hi == 4'h3) chk(16'(zero_clamp), 16'h0001);
      else chk(16'(drive_enable), 16'h0000);
      ref_dir_rev = 1;
      wait_mode(OTSC_OUT_RUN);
      chk(16'(drive_enable), 16'h0001);
    end
    // torque control: no deceleration, lower-digit method then coasting
    restart(4'h1, 4'h2, 8'h10);
    torque_mode = 1;
    fwd_hit = 1;
    cyc(5);
    chk(16'(dyn_brake), 16'h0001);
    wait_mode(OTSC_OUT_COAST);
    torque_mode = 0;
    // reverse limit, and forward limit hit while moving in reverse
    restart(4'h1, 4'h2, 8'h00);
    ref_dir_rev = 1;
    fwd_hit = 1;
    cyc(8);
    chk(16'({fwd_ot, 6'h0, stop_mode}), 16'h0100);
    rev_hit = 1;
    cyc(5);
    chk(16'(rev_ot), 16'h0001);
    wait_mode(OTSC_OUT_DB);
    // both limits disabled: open switches are ignored
    restart(4'h8, 4'h8, 8'h00);
    fwd_hit = 1;
    rev_hit = 1;
    cyc(8);
    chk(16'({fwd_ot, rev_ot}), 16'h0000);
    chk(16'({drive_enable, 6'h0, stop_mode}), 16'h0100);
    ref_dir_rev = 1;
    cyc(3);
    chk(16'({drive_enable, 6'h0, stop_mode}), 16'h0100);
    tally_and_finish();
  end
endmodule
